// ### design/pss_defs.svh
// Constants of the pipelined synchronous SRAM port.
// Assumes nothing; included by the package, the design modules and the checker.
`ifndef PSS_DEFS_SVH
`define PSS_DEFS_SVH

`define PSS_AW       18
`define PSS_HI_AW    16
`define PSS_BURST_W  2
`define PSS_LANES    4
`define PSS_LANE_W   9
`define PSS_BYTE_W   8
`define PSS_DW       36
`define PSS_DEPTH    262144
`define PSS_SYNC_W   2
`define PSS_CLK_NS   20

`endif

// ### design/pss_pkg.sv
// Types shared by the SRAM port modules.
// Assumes pss_defs.svh is on the include path.
`include "pss_defs.svh"

package pss_pkg;

  typedef enum logic [1:0] {
    PSS_ACTIVE = 2'h0,
    PSS_SNOOZE = 2'h1
  } pss_mode_t;

  typedef struct packed {
    logic                    valid;
    logic                    write;
    logic [`PSS_AW-1:0]      addr;
    logic [`PSS_LANES-1:0]   bw_n;
  } pss_cmd_t;

  typedef struct packed {
    logic                    cke_n;
    logic                    cs_n;
    logic                    cs2_n;
    logic                    cs_high;
    logic                    rw_n;
    logic                    step;
    logic [`PSS_LANES-1:0]   bw_n;
    logic [`PSS_AW-1:0]      addr;
  } pss_pins_t;

endpackage

// ### design/pss_burst_ctr.sv
// Two-bit burst address sequencer, linear or interleaved.
// Assumes en is the enabled-edge qualifier of the owning port.
`timescale 1ns/1ps
`include "pss_defs.svh"

module pss_burst_ctr (
  input  wire logic                    clock,
  input  wire logic                    rstn,
  input  wire logic                    en,
  input  wire logic                    load,
  input  wire logic                    interleave,
  input  wire logic [`PSS_BURST_W-1:0] base,
  output logic      [`PSS_BURST_W-1:0] low_next
);
  import pss_pkg::*;

  logic [`PSS_BURST_W-1:0] base_q;
  logic [`PSS_BURST_W-1:0] base_d;
  logic [`PSS_BURST_W-1:0] cnt_q;
  logic [`PSS_BURST_W-1:0] cnt_d;
  logic [`PSS_BURST_W-1:0] cnt_inc;

  always_comb begin
    cnt_inc = cnt_q + `PSS_BURST_W'h1;
    base_d  = base_q;
    cnt_d   = cnt_q;
    if (en) begin
      if (load) begin
        base_d = base;
        cnt_d  = '0;
      end else begin
        cnt_d  = cnt_inc;  // see RL15
      end
    end
    // Address of the next advance beat, wraps within the burst
    if (interleave) begin
      low_next = base_q ^ cnt_inc;  // see RL16
    end else begin
      low_next = base_q + cnt_inc;  // see RL16
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      base_q <= '0;
      cnt_q  <= '0;
    end else begin
      base_q <= base_d;
      cnt_q  <= cnt_d;
    end
  end

endmodule

// ### design/pss_sram_port.sv
// Pipelined synchronous SRAM port: registered control, 256K x 36 array.
// Assumes a controller on the same clock drives the synchronous pins;
// snooze and output enable arrive asynchronously.
`timescale 1ns/1ps
`include "pss_defs.svh"

// What this block does
// RL1 - Address inputs are registered on the rising clock edge.
// RL2 - Active-low lane write enables; only enabled lanes change, others keep data.
// RL3 - Controller drives lane enables low to write, high to read.
// RL4 - Each lane enable covers its data byte and its parity bit.
// RL5 - Parity bits exist in 18- and 36-bit builds; this is 36-bit.
// RL6 - Clock enable high freezes pipeline, burst counter and read data; only enabled edges act.
// RL7 - Read/write select sets cycle type only on address load cycles.
// RL8 - Read stays read, write stays write, until a new address load.
// RL9 - Select low enables writing; all lane enables low writes full width.
// RL10 - Address, data, selects, lane enables and burst control sampled on edge.
// RL11 - Primary chip select is only looked at on load cycles.
// RL12 - Selected only with select low, second select low, high select high.
// RL13 - Snooze enters standby regardless of clock; array is retained.
// RL14 - During snooze every other input is ignored.
// RL15 - Step level advances burst counter, ignores read/write; low loads address.
// RL16 - Order select low linear, high interleaved; held constant in operation.
// RL17 - Asynchronous output enable gates the data drivers.
// RL18 - Read data out and write data in two enabled edges after address.
module pss_sram_port (
  input  wire logic              clock,
  input  wire logic              rstn,
  input  wire logic [`PSS_HI_AW-1:0] sync_address_bus,
  input  wire logic              addr_bit_low1,
  input  wire logic              addr_bit_low0,
  input  wire logic              lane_a_write_enable_n,
  input  wire logic              lane_b_write_enable_n,
  input  wire logic              lane_c_write_enable_n,
  input  wire logic              lane_d_write_enable_n,
  input  wire logic              clock_enable_n,
  input  wire logic              chip_select_n,
  input  wire logic              chip_select_second_n,
  input  wire logic              chip_select_high,
  input  wire logic              read_write_n,
  input  wire logic              burst_step_or_load,
  input  wire logic              burst_order_select,
  input  wire logic              output_enable_n,
  input  wire logic              snooze_request,
  input  wire logic [`PSS_DW-1:0] data_in,
  output logic      [`PSS_DW-1:0] data_out,
  output logic                   data_oe_n,
  output pss_pkg::pss_mode_t     power_mode
);
  import pss_pkg::*;

  // Asynchronous pins: two-stage synchronisers
  logic [`PSS_SYNC_W-1:0] zz_sync_q;
  logic [`PSS_SYNC_W-1:0] zz_sync_d;
  logic [`PSS_SYNC_W-1:0] oe_sync_q;
  logic [`PSS_SYNC_W-1:0] oe_sync_d;
  logic                   zz_s;
  logic                   oe_s_n;

  pss_mode_t              mode_q;
  pss_mode_t              mode_d;

  pss_pins_t              pin;
  logic                   run;
  logic                   load;
  logic                   selected;
  logic [`PSS_BURST_W-1:0] low_next;

  pss_cmd_t               s1_q;
  pss_cmd_t               s1_d;
  pss_cmd_t               s2_q;
  pss_cmd_t               s2_d;

  logic [`PSS_DW-1:0]     mem_q [0:`PSS_DEPTH-1];
  logic [`PSS_DW-1:0]     old_word;
  logic [`PSS_DW-1:0]     lane_mask;
  logic [`PSS_DW-1:0]     wr_word;
  logic                   wr_en;

  logic [`PSS_DW-1:0]     dout_q;
  logic [`PSS_DW-1:0]     dout_d;
  logic                   drive_q;
  logic                   drive_d;
  logic                   oe_n_q;
  logic                   oe_n_d;

  always_comb begin
    zz_sync_d = {zz_sync_q[0], snooze_request};
    oe_sync_d = {oe_sync_q[0], output_enable_n};
    zz_s      = zz_sync_q[1];
    oe_s_n    = oe_sync_q[1];
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      zz_sync_q <= '0;
      oe_sync_q <= '1;
    end else begin
      zz_sync_q <= zz_sync_d;
      oe_sync_q <= oe_sync_d;
    end
  end

  // Power mode follows snooze regardless of clock enable
  always_comb begin
    mode_d = zz_s ? PSS_SNOOZE : PSS_ACTIVE;  // see RL13
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      mode_q <= PSS_ACTIVE;
    end else begin
      mode_q <= mode_d;
    end
  end

  // Synchronous pins gathered, all sampled at the rising edge
  always_comb begin
    pin.cke_n   = clock_enable_n;
    pin.cs_n    = chip_select_n;
    pin.cs2_n   = chip_select_second_n;
    pin.cs_high = chip_select_high;
    pin.rw_n    = read_write_n;
    pin.step    = burst_step_or_load;
    pin.bw_n    = {lane_d_write_enable_n, lane_c_write_enable_n,
                   lane_b_write_enable_n, lane_a_write_enable_n};
    pin.addr    = {sync_address_bus, addr_bit_low1, addr_bit_low0};
    // Snooze masks everything, clock enable masks the edge
    run      = !zz_s && !pin.cke_n;  // see RL6 see RL14
    load     = !pin.step;  // see RL15
    selected = !pin.cs_n && !pin.cs2_n && pin.cs_high;  // see RL12
  end

  pss_burst_ctr u_burst (
    .clock      (clock),
    .rstn       (rstn),
    .en         (run),
    .load       (load),
    .interleave (burst_order_select),
    .base       (pin.addr[`PSS_BURST_W-1:0]),
    .low_next   (low_next)
  );

  // Address stage
  always_comb begin
    s1_d = s1_q;
    if (run) begin
      s1_d.bw_n = pin.bw_n;  // see RL10
      if (load) begin
        s1_d.valid = selected;  // see RL11
        s1_d.write = !pin.rw_n;  // see RL7 see RL9
        s1_d.addr  = pin.addr;  // see RL1
      end else begin
        // Type kept, select and read/write ignored
        s1_d.addr[`PSS_BURST_W-1:0] = low_next;  // see RL8 see RL15
      end
    end
  end

  // Middle stage: gives the two-edge pipeline
  always_comb begin
    s2_d = run ? s1_q : s2_q;  // see RL18
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end

  // Data stage: byte-lane merge of the write word
  always_comb begin
    old_word = mem_q[s2_q.addr];
    for (int i = 0; i < `PSS_LANES; i++) begin
      // Lane covers its byte and its parity bit
      lane_mask[i*`PSS_LANE_W +: `PSS_LANE_W] = {`PSS_LANE_W{!s2_q.bw_n[i]}};  // see RL4
    end
    wr_word = (old_word & ~lane_mask) | (data_in & lane_mask);  // see RL2 see RL5
    wr_en   = run && s2_q.valid && s2_q.write;  // see RL18
  end

  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem_q[s2_q.addr] <= wr_word;  // see RL13
    end
  end

  // Read output register and drivers
  always_comb begin
    dout_d  = dout_q;
    drive_d = drive_q;
    if (run) begin
      drive_d = s2_q.valid && !s2_q.write;
      if (drive_d) begin
        dout_d = old_word;  // see RL18
      end
    end
    oe_n_d = !(drive_d && !oe_s_n && !zz_s);  // see RL17
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      dout_q  <= '0;
      drive_q <= 1'b0;
      oe_n_q  <= 1'b1;
    end else begin
      dout_q  <= dout_d;
      drive_q <= drive_d;
      oe_n_q  <= oe_n_d;
    end
  end

  always_comb begin
    data_out   = dout_q;
    data_oe_n  = oe_n_q;
    power_mode = mode_q;
  end

endmodule

// ### testbench/pss_port_properties.sv
// Timing checker for the SRAM port outputs.
// Assumes binding into pss_sram_port; sees its ports only.
`timescale 1ns/1ps
`include "pss_defs.svh"

module pss_port_chk (
  input wire logic               clock,
  input wire logic               rstn,
  input wire logic               read_write_n,
  input wire logic               burst_step_or_load,
  input wire logic               clock_enable_n,
  input wire logic               chip_select_n,
  input wire logic               chip_select_second_n,
  input wire logic               chip_select_high,
  input wire logic               output_enable_n,
  input wire logic               snooze_request,
  input wire logic [`PSS_DW-1:0] data_out,
  input wire logic               data_oe_n,
  input wire pss_pkg::pss_mode_t power_mode
);
  import pss_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  logic run;
  logic rd_load;
  logic idle_load;
  assign run = !clock_enable_n && power_mode == PSS_ACTIVE;
  assign rd_load = read_write_n && !burst_step_or_load && !chip_select_n;
  assign idle_load = chip_select_n || chip_select_second_n || !chip_select_high;

  stall_hold_a: assert property (
    clock_enable_n |=> $stable(data_out) && $stable(data_oe_n)) else $error("stall moved outputs");
  snooze_on_a: assert property (
    snooze_request [*4] |-> power_mode == PSS_SNOOZE) else $error("standby not entered");
  snooze_off_a: assert property (
    !snooze_request [*4] |-> power_mode == PSS_ACTIVE) else $error("standby not left");
  snooze_freeze_a: assert property (
    power_mode == PSS_SNOOZE |-> $stable(data_out) && $stable(data_oe_n))
    else $error("outputs moved in standby");
  read_lat_a: assert property (
    $fell(data_oe_n) && !$past(clock_enable_n, 3) |-> $past(rd_load, 3))
    else $error("read data without read load");
  write_quiet_a: assert property (
    !burst_step_or_load && !read_write_n && !clock_enable_n ##1 run [*2] ##1
    power_mode == PSS_ACTIVE |-> data_oe_n) else $error("write slot drove data");
  desel_quiet_a: assert property (
    !burst_step_or_load && idle_load && !clock_enable_n ##1 run [*2] ##1
    power_mode == PSS_ACTIVE |-> data_oe_n) else $error("idle slot drove data");
  oe_gate_a: assert property (
    (output_enable_n && run) [*4] |-> data_oe_n) else $error("drivers on with enable high");
endmodule

bind pss_sram_port pss_port_chk pss_port_chk_inst (.clock, .rstn, .read_write_n,
  .burst_step_or_load, .clock_enable_n, .chip_select_n, .chip_select_second_n,
  .chip_select_high, .output_enable_n, .snooze_request, .data_out, .data_oe_n, .power_mode);

// ### testbench/pss_ctrl_model.sv
// Controller model turning bench commands into port pins.
// Assumes the bench changes its inputs at the falling edge.
`timescale 1ns/1ps

module pss_ctrl_model (
  input  wire logic              stall,
  input  wire logic              step,
  input  wire logic [1:0]        drop,
  input  wire pss_pkg::pss_cmd_t cmd,
  output pss_pkg::pss_pins_t     pins
);
  import pss_pkg::*;
  always_comb begin
    pins.cke_n = stall;
    pins.step = step;
    pins.addr = cmd.addr;
    // Advance beats carry a write type and a dropped select on purpose
    pins.rw_n = step ? 1'b0 : !cmd.write;
    pins.bw_n = cmd.write ? cmd.bw_n : 4'hf;
    pins.cs_n = step || !cmd.valid || drop == 2'h1;
    pins.cs2_n = drop == 2'h2;
    pins.cs_high = drop != 2'h3;
  end
endmodule

// ### testbench/tb_pipelined_sync_sram_port.sv
// Self-checking bench for the SRAM port.
// Assumes the controller model and the bound checker.
`timescale 1ns/1ps

module tb_pipelined_sync_sram_port;
  import pss_pkg::*;
  localparam logic [17:0] adr3 = 18'h2a5f7;
  localparam logic [17:0] adr0 = 18'h2a5f4;
  localparam logic [35:0] dat1 = 36'h93c5a17e2;
  localparam logic [35:0] dat2 = 36'h6d2e4b91c;
  logic        clock = 1'b0, rstn = 1'b0, stall = 1'b0, step = 1'b0, oe_n = 1'b0, snz = 1'b0;
  logic [1:0]  drop = 2'h0;
  logic        order_sel = 1'b0;
  logic [35:0] data_in = 36'h0, data_out;
  logic        data_oe_n;
  pss_cmd_t    cmd = '0;
  pss_pins_t   pins;
  pss_mode_t   power_mode;
  int          num_errors = 0, checks = 0;

  always #10 clock = ~clock;

  pss_ctrl_model pss_ctrl_model_inst (.stall, .step, .drop, .cmd, .pins);
  pss_sram_port pss_sram_port_inst (
    .clock, .rstn, .data_in, .data_out, .data_oe_n, .power_mode,
    .sync_address_bus      (pins.addr[17:2]),
    .addr_bit_low1         (pins.addr[1]),
    .addr_bit_low0         (pins.addr[0]),
    .lane_a_write_enable_n (pins.bw_n[0]),
    .lane_b_write_enable_n (pins.bw_n[1]),
    .lane_c_write_enable_n (pins.bw_n[2]),
    .lane_d_write_enable_n (pins.bw_n[3]),
    .clock_enable_n        (pins.cke_n),
    .chip_select_n         (pins.cs_n),
    .chip_select_second_n  (pins.cs2_n),
    .chip_select_high      (pins.cs_high),
    .read_write_n          (pins.rw_n),
    .burst_step_or_load    (pins.step),
    .burst_order_select    (order_sel),
    .output_enable_n       (oe_n),
    .snooze_request        (snz)
  );

  task automatic end_sim;
    if (num_errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [36:0] got, input logic [36:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Load, one idle beat, data at the second edge after the load
  task automatic op(input logic w, input logic [17:0] a, input logic [3:0] bw,
                    input logic [35:0] d);
    cmd = '{1'b1, w, a, bw};
    @(negedge clock);
    cmd.valid = 1'b0;
    @(negedge clock);
    data_in = d;
    @(negedge clock);
    data_in = ~d;
    if (!w) chk({data_oe_n, oe_n ? d : data_out}, {oe_n, d});
  endtask

  task automatic wait_mode(input pss_mode_t m);
    for (int i = 0; i < 8 && power_mode !== m; i++) @(negedge clock);
    chk({35'h0, power_mode}, {35'h0, m});
    if (power_mode !== m) end_sim();
  endtask

  task automatic t_lanes;
    logic [35:0] exp, m;
    op(1'b1, adr3, 4'h0, dat1);
    op(1'b0, adr3, 4'hf, dat1);
    exp = dat1;
    for (int i = 0; i < 4; i++) begin
      m = 36'h1ff << (9 * i);
      exp = (exp & ~m) | ((dat2 + 36'(i)) & m);
      op(1'b1, adr3, ~(4'h1 << i), dat2 + 36'(i));
      op(1'b0, adr3, 4'hf, exp);
    end
  endtask

  task automatic t_desel;
    op(1'b1, adr0, 4'h0, dat1);
    for (int k = 1; k < 4; k++) begin
      drop = 2'(k);
      op(1'b1, adr0, 4'h0, ~dat1);
      drop = 2'h0;
      op(1'b0, adr0, 4'hf, dat1);
    end
  endtask

  task automatic t_stall;
    cmd = '{1'b1, 1'b0, adr0, 4'hf};
    @(negedge clock);
    cmd.valid = 1'b0;
    stall = 1'b1;
    repeat (3) @(negedge clock);
    chk({36'h0, data_oe_n}, 37'h1);
    stall = 1'b0;
    repeat (2) @(negedge clock);
    chk({data_oe_n, data_out}, {1'b0, dat1});
  endtask

  task automatic t_burst;
    op(1'b1, adr3, 4'h0, dat1);
    op(1'b1, adr0, 4'h0, dat2);
    op(1'b1, adr3 ^ 18'h1, 4'h0, ~dat2);
    // Order is changed only between bursts, never inside one
    for (int o = 0; o < 2; o++) begin
      order_sel = 1'(o);
      cmd = '{1'b1, 1'b0, adr3, 4'hf};
      @(negedge clock);
      step = 1'b1;
      @(negedge clock);
      step = 1'b0;
      cmd.valid = 1'b0;
      @(negedge clock);
      chk({data_oe_n, data_out}, {1'b0, dat1});
      @(negedge clock);
      chk({data_oe_n, data_out}, {1'b0, (o != 0) ? ~dat2 : dat2});
    end
    order_sel = 1'b0;
  endtask

  task automatic t_oe;
    oe_n = 1'b1;
    repeat (3) @(negedge clock);
    op(1'b0, adr3, 4'hf, dat1);
    oe_n = 1'b0;
    repeat (3) @(negedge clock);
  endtask

  task automatic t_snooze;
    snz = 1'b1;
    wait_mode(PSS_SNOOZE);
    op(1'b1, adr3, 4'h0, dat2);
    snz = 1'b0;
    wait_mode(PSS_ACTIVE);
    op(1'b0, adr3, 4'hf, dat1);
  endtask

  initial begin
    repeat (2) @(negedge clock);
    rstn = 1'b1;
    t_lanes();
    t_desel();
    t_stall();
    t_burst();
    t_oe();
    t_snooze();
    end_sim();
  end
endmodule
